/* pkg/tpss_consts.svh */
// offsets, field positions, reset values and timing counts of the touch scan sequencer
`ifndef TPSS_CONSTS_SVH
`define TPSS_CONSTS_SVH
`define TPSS_ADDR_W 8
`define TPSS_ADDR_DATA 8'h00
`define TPSS_ADDR_CTRL 8'h04
`define TPSS_ADDR_STAT 8'h08
`define TPSS_ADDR_IVL 8'h0C
`define TPSS_ADDR_CMD 8'h10
`define TPSS_ADDR_CDIV 8'h14
`define TPSS_CTL_EN 0
`define TPSS_CTL_PWR 1
`define TPSS_CTL_URST 2
`define TPSS_CTL_MODE 3
`define TPSS_CTL_PRESS 5
`define TPSS_CTL_START 6
`define TPSS_CTL_STOP 7
`define TPSS_CTL_ASTART 8
`define TPSS_CTL_ASTOP 9
`define TPSS_CTL_ASCAN 10
`define TPSS_CTL_DMAMSK 11
`define TPSS_CMD_CCMD 8
`define TPSS_IVL_RST 16'h0010
`define TPSS_CDIV_RST 8'h04
`define TPSS_FRAME_BITS 4'hC
`define TPSS_PEN_CHECK_TICKS 3'h4
`define TPSS_DRV_IDLE 5'h00
`define TPSS_DRV_TOUCH 5'h10
`define TPSS_DRV_XFWD 5'h03
`define TPSS_DRV_XREV 5'h05
`define TPSS_DRV_YFWD 5'h09
`define TPSS_DRV_YREV 5'h11
`define TPSS_DRV_PRESS 5'h06
`define TPSS_CH_X 4'h0
`define TPSS_CH_Y 4'h1
`define TPSS_CH_PRESS 4'h2
`define TPSS_CH_MAIN 4'h3
`define TPSS_CH_SUB 4'h4
`define TPSS_RESP_OKAY 2'h0
`define TPSS_RESP_SLVERR 2'h2
`endif

/* pkg/tpss_pkg.sv */
// types of the touch scan sequencer
package tpss_pkg;
  typedef enum logic [2:0] {
    TPSS_DISABLED = 3'h0,
    TPSS_STANDBY = 3'h1,
    TPSS_MAIN_BATT = 3'h2,
    TPSS_SUB_BATT = 3'h3,
    TPSS_WAIT_TOUCH = 3'h4,
    TPSS_COORD_SCAN = 3'h5,
    TPSS_INTERVAL_WAIT = 3'h6,
    TPSS_COMMAND = 3'h7
  } tpss_state_t;
  typedef enum logic [1:0] {
    TPSS_MODE_COORD = 2'h0,
    TPSS_MODE_CMD = 2'h1,
    TPSS_MODE_MAIN = 2'h2,
    TPSS_MODE_SUB = 2'h3
  } tpss_mode_t;
endpackage

/* hdl/tpss_top.sv */
// touch panel scan sequencer with converter interface and AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "tpss_consts.svh"

// Overview of operation
// - disabled: pins high impedance, inputs masked
// - standby: no panel drive, converter deselected
// - main battery: one conversion, data out, sample ready, back to standby
// - sub battery: one conversion, data out, sample ready, back to standby
// - command state: drive and converter command from manual command register
// - wait touch: touch raises pen change; auto scan moves to coordinate scan
// - transition checked four converter clocks after pen change; release stays
// - waiting for touch signals that suspend is allowed
// - coordinate: four or five conversions, DMA each, sample ready after all
// - sequencer runs with DMA masked; overwrite of unread data flags overrun
// - overrun ends coordinate early unless DMA masked
// - interval wait returns to scanning after programmed interval
// - release in interval: pen change; auto stop rescans at once
// - each axis measured twice with drive direction reversed
// - panel driver steered by a five-bit field
// - converter clock generated here with programmable period
// - serial result made parallel; bus, DMA, registers handled here
// - sequencer state reported as a three-bit code
// - two-bit mode selects coordinate, command, main or sub battery
// - auto start on touch starts the sequencer from standby into wait touch on panel touch in coordinate mode
module tpss_top #(
  parameter int DIV_W = 8,
  parameter int IVL_W = 16
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic dma_req, // sample waiting for DMA
  input wire logic dma_ack, // DMA took the sample
  output logic [11:0] dma_data, // sample for DMA
  output logic sample_ready_irq, // pulse: sample set complete
  output logic pen_change_irq, // pulse: touch or release seen
  output logic sample_overrun_irq, // pulse: unread sample overwritten
  output logic suspend_ok, // bus side clock may stop
  input wire logic pen_touch, // panel touch sense pin
  input wire logic conv_dout, // converter serial result pin
  output logic converter_clock, // converter clock pin
  output logic conv_cs_n, // converter select pin
  output logic conv_din, // converter command pin
  output logic [4:0] panel_drive_field, // panel driver control pins
  output logic pins_oe // output enable of all pins
);
  tpss_pkg::tpss_state_t state_q, state_d;
  logic en_q, pwr_q, press_q, start_q, stop_q, astart_q, astop_q, ascan_q, dmamsk_q;
  logic [1:0] mode_q;
  logic [IVL_W-1:0] sample_interval_reg, ivl_cnt_q;
  logic [12:0] manual_command_reg;
  logic [DIV_W-1:0] cdiv_q, div_cnt_q;
  logic [11:0] data_q, shift_q, cmd_sh_q;
  logic [3:0] bit_cnt_q;
  logic [2:0] idx_q, chk_q;
  logic pen_m1_q, pen_s_q, dout_m1_q, dout_s_q, pen_prev_q;
  logic clk_q, busy_q, unread_q, cs_n_q, din_q, oe_q, fell_q;
  logic [4:0] drive_q;
  logic aw_v_q, w_v_q, bv_q, rv_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] br_q, rr_q;
  logic rdy_q, pen_irq_q, ovr_q, susp_q;

  // bus slave
  wire wr_go = aw_v_q && w_v_q && !bv_q;
  wire rd_go = s_axi_arvalid && !rv_q;
  wire wr_ctrl = wr_go && ws_q[0] && aw_q == `TPSS_ADDR_CTRL;
  wire wr_ctrl_hi = wr_go && ws_q[1] && aw_q == `TPSS_ADDR_CTRL;
  wire rd_data = rd_go && s_axi_araddr == `TPSS_ADDR_DATA;
  wire wr_map = aw_q <= `TPSS_ADDR_CDIV && aw_q[1:0] == 2'h0;
  wire rd_map = s_axi_araddr <= `TPSS_ADDR_CDIV && s_axi_araddr[1:0] == 2'h0;
  wire unit_rst = wr_ctrl && wd_q[`TPSS_CTL_URST];
  assign s_axi_awready = !aw_v_q;
  assign s_axi_wready = !w_v_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  // pin synchronisers, inputs masked while unpowered
  wire pen_m = pen_s_q && pwr_q;
  wire dout_m = dout_s_q && pwr_q;
  wire pen_rise = pen_m && !pen_prev_q;
  wire pen_fall = !pen_m && pen_prev_q;

  // converter clock divider
  wire div_wrap = div_cnt_q >= cdiv_q;
  wire tick_rise = div_wrap && !clk_q;
  wire tick_fall = div_wrap && clk_q;
  wire in_conv = state_q == tpss_pkg::TPSS_MAIN_BATT || state_q == tpss_pkg::TPSS_SUB_BATT
    || state_q == tpss_pkg::TPSS_COMMAND || state_q == tpss_pkg::TPSS_COORD_SCAN;
  wire conv_done = in_conv && busy_q && tick_rise && bit_cnt_q == `TPSS_FRAME_BITS - 4'h1;
  wire conv_go = in_conv && !busy_q && fell_q; // frame opens just after a clock fall

  // per conversion drive and converter command
  logic [4:0] drive_sel;
  logic [3:0] ch_sel;
  always_comb begin
    drive_sel = `TPSS_DRV_IDLE;
    ch_sel = `TPSS_CH_X;
    unique case (state_q)
      tpss_pkg::TPSS_MAIN_BATT: ch_sel = `TPSS_CH_MAIN;
      tpss_pkg::TPSS_SUB_BATT: ch_sel = `TPSS_CH_SUB;
      tpss_pkg::TPSS_COMMAND: begin
        drive_sel = manual_command_reg[4:0];
        ch_sel = manual_command_reg[12:9];
      end
      tpss_pkg::TPSS_COORD_SCAN: begin
        unique case (idx_q)
          3'h0: begin drive_sel = `TPSS_DRV_XFWD; ch_sel = `TPSS_CH_Y; end
          3'h1: begin drive_sel = `TPSS_DRV_XREV; ch_sel = `TPSS_CH_Y; end
          3'h2: begin drive_sel = `TPSS_DRV_YFWD; ch_sel = `TPSS_CH_X; end
          3'h3: begin drive_sel = `TPSS_DRV_YREV; ch_sel = `TPSS_CH_X; end
          default: begin drive_sel = `TPSS_DRV_PRESS; ch_sel = `TPSS_CH_PRESS; end
        endcase
      end
      tpss_pkg::TPSS_WAIT_TOUCH, tpss_pkg::TPSS_INTERVAL_WAIT: drive_sel = `TPSS_DRV_TOUCH;
      default: drive_sel = `TPSS_DRV_IDLE;
    endcase
  end

  // sample hand-off and overrun
  wire unread_clr = rd_data || dma_ack;
  wire overrun = conv_done && unread_q;
  wire [2:0] need_n = press_q ? 3'h5 : 3'h4;
  wire scan_last = conv_done && idx_q == need_n - 3'h1;
  wire scan_end = state_q == tpss_pkg::TPSS_COORD_SCAN && (scan_last || overrun);
  wire scan_fin = scan_end && !dmamsk_q;
  wire batt_fin = conv_done && (state_q == tpss_pkg::TPSS_MAIN_BATT
    || state_q == tpss_pkg::TPSS_SUB_BATT || state_q == tpss_pkg::TPSS_COMMAND);
  wire chk_now = chk_q == 3'h1 && tick_rise;
  wire ivl_done = ivl_cnt_q >= sample_interval_reg;
  wire auto_go = astart_q && pen_m && mode_q == tpss_pkg::TPSS_MODE_COORD;
  wire rel_stop = state_q == tpss_pkg::TPSS_INTERVAL_WAIT && pen_fall && astop_q;
  assign dma_req = unread_q && !dmamsk_q;
  assign dma_data = data_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tpss_pkg::TPSS_DISABLED: if (pwr_q) state_d = tpss_pkg::TPSS_STANDBY;
      tpss_pkg::TPSS_STANDBY: begin
        if (en_q) begin
          unique case (tpss_pkg::tpss_mode_t'(mode_q))
            tpss_pkg::TPSS_MODE_CMD: state_d = tpss_pkg::TPSS_COMMAND;
            tpss_pkg::TPSS_MODE_MAIN: state_d = tpss_pkg::TPSS_MAIN_BATT;
            tpss_pkg::TPSS_MODE_SUB: state_d = tpss_pkg::TPSS_SUB_BATT;
            tpss_pkg::TPSS_MODE_COORD: state_d = start_q ? tpss_pkg::TPSS_COORD_SCAN
              : tpss_pkg::TPSS_WAIT_TOUCH;
          endcase
        end else if (auto_go) state_d = tpss_pkg::TPSS_WAIT_TOUCH;
      end
      tpss_pkg::TPSS_MAIN_BATT, tpss_pkg::TPSS_SUB_BATT, tpss_pkg::TPSS_COMMAND:
        if (batt_fin) state_d = tpss_pkg::TPSS_STANDBY;
      tpss_pkg::TPSS_WAIT_TOUCH:
        if (chk_now && pen_m && (ascan_q || astart_q)) state_d = tpss_pkg::TPSS_COORD_SCAN;
      tpss_pkg::TPSS_COORD_SCAN:
        if (scan_fin) state_d = stop_q ? tpss_pkg::TPSS_STANDBY : tpss_pkg::TPSS_INTERVAL_WAIT;
      tpss_pkg::TPSS_INTERVAL_WAIT:
        if (rel_stop || ivl_done) state_d = tpss_pkg::TPSS_COORD_SCAN;
    endcase
    if (!en_q && state_q != tpss_pkg::TPSS_DISABLED && !auto_go) begin
      state_d = tpss_pkg::TPSS_STANDBY;
    end
    if (!pwr_q || unit_rst) state_d = tpss_pkg::TPSS_DISABLED;
  end

  wire [31:0] ctrl_word = {20'h00000, dmamsk_q, ascan_q, astop_q, astart_q, stop_q, start_q,
    press_q, mode_q, 1'b0, pwr_q, en_q};
  wire [31:0] rd_word =
    s_axi_araddr == `TPSS_ADDR_DATA ? {20'h00000, data_q} :
    s_axi_araddr == `TPSS_ADDR_CTRL ? ctrl_word :
    s_axi_araddr == `TPSS_ADDR_STAT ? {27'h0000000, pen_prev_q, pen_m, state_q} :
    s_axi_araddr == `TPSS_ADDR_IVL ? {{(32-IVL_W){1'b0}}, sample_interval_reg} :
    s_axi_araddr == `TPSS_ADDR_CMD ? {19'h00000, manual_command_reg} :
    s_axi_araddr == `TPSS_ADDR_CDIV ? {{(32-DIV_W){1'b0}}, cdiv_q} : 32'h00000000;

  // bus channels
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      br_q <= `TPSS_RESP_OKAY;
      rr_q <= `TPSS_RESP_OKAY;
      rd_q <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && !aw_v_q) begin
        aw_q <= s_axi_awaddr;
        aw_v_q <= 1'b1;
      end else if (wr_go) aw_v_q <= 1'b0;
      if (s_axi_wvalid && !w_v_q) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_v_q <= 1'b1;
      end else if (wr_go) w_v_q <= 1'b0;
      if (wr_go) begin
        bv_q <= 1'b1;
        br_q <= wr_map ? `TPSS_RESP_OKAY : `TPSS_RESP_SLVERR;
      end else if (s_axi_bready) bv_q <= 1'b0;
      if (rd_go) begin
        rv_q <= 1'b1;
        rr_q <= rd_map ? `TPSS_RESP_OKAY : `TPSS_RESP_SLVERR;
        rd_q <= rd_word;
      end else if (s_axi_rready) rv_q <= 1'b0;
    end
  end

  // control registers; the release set of stop_q wins over a software clear, a control write wins over other hardware updates
  wire en_hw_clr = batt_fin || (scan_fin && stop_q);
  always_ff @(posedge clock) begin
    if (rst) begin
      {en_q, pwr_q, press_q, start_q, stop_q, astart_q, astop_q, ascan_q, dmamsk_q} <= 9'h000;
      mode_q <= 2'h0;
      sample_interval_reg <= IVL_W'(`TPSS_IVL_RST);
      manual_command_reg <= 13'h0000;
      cdiv_q <= DIV_W'(`TPSS_CDIV_RST);
    end else begin
      if (wr_ctrl) begin
        {start_q, press_q, mode_q} <= wd_q[`TPSS_CTL_START:`TPSS_CTL_MODE];
        pwr_q <= wd_q[`TPSS_CTL_PWR] && !unit_rst;
        en_q <= wd_q[`TPSS_CTL_EN] && !unit_rst;
        stop_q <= wd_q[`TPSS_CTL_STOP] || rel_stop;
      end else begin
        if (en_hw_clr || unit_rst) en_q <= 1'b0;
        if (state_q == tpss_pkg::TPSS_STANDBY && auto_go) en_q <= 1'b1;
        if (state_q == tpss_pkg::TPSS_COORD_SCAN) start_q <= 1'b0;
        if (rel_stop) stop_q <= 1'b1;
        else if (scan_fin && stop_q) stop_q <= 1'b0;
      end
      if (wr_ctrl_hi) begin
        {dmamsk_q, ascan_q, astop_q, astart_q} <= wd_q[`TPSS_CTL_DMAMSK:`TPSS_CTL_ASTART];
      end
      if (wr_go && aw_q == `TPSS_ADDR_IVL) sample_interval_reg <= wd_q[IVL_W-1:0];
      if (wr_go && aw_q == `TPSS_ADDR_CMD) manual_command_reg <= wd_q[12:0];
      if (wr_go && aw_q == `TPSS_ADDR_CDIV) cdiv_q <= wd_q[DIV_W-1:0];
    end
  end

  // sequencer, converter frame and pins
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= tpss_pkg::TPSS_DISABLED;
      {pen_m1_q, pen_s_q, dout_m1_q, dout_s_q, pen_prev_q} <= 5'h00;
      {clk_q, busy_q, unread_q, din_q, oe_q, susp_q, fell_q} <= 7'h00;
      {rdy_q, pen_irq_q, ovr_q} <= 3'h0;
      cs_n_q <= 1'b1;
      div_cnt_q <= '0;
      ivl_cnt_q <= '0;
      {bit_cnt_q, idx_q, chk_q} <= 10'h000;
      {data_q, shift_q, cmd_sh_q} <= 36'h000000000;
      drive_q <= `TPSS_DRV_IDLE;
    end else begin
      state_q <= state_d;
      {pen_m1_q, pen_s_q} <= {pen_touch, pen_m1_q};
      {dout_m1_q, dout_s_q} <= {conv_dout, dout_m1_q};
      pen_prev_q <= pen_m;
      oe_q <= state_d != tpss_pkg::TPSS_DISABLED;
      susp_q <= state_d == tpss_pkg::TPSS_WAIT_TOUCH;
      fell_q <= tick_fall;
      div_cnt_q <= (div_wrap || !pwr_q) ? '0 : div_cnt_q + 1'b1;
      if (div_wrap) clk_q <= !clk_q && pwr_q;
      if (conv_go) begin
        busy_q <= 1'b1;
        cs_n_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        cmd_sh_q <= {ch_sel, 8'h00};
        drive_q <= drive_sel;
      end else if (!in_conv) begin
        busy_q <= 1'b0;
        cs_n_q <= 1'b1;
        drive_q <= drive_sel;
      end else if (busy_q && tick_rise) begin
        shift_q <= {shift_q[10:0], dout_m};
        cmd_sh_q <= {cmd_sh_q[10:0], 1'b0};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (conv_done) busy_q <= 1'b0;
      end else if (!busy_q) cs_n_q <= 1'b1; // select drops one clock after the last rise
      if (conv_go) din_q <= ch_sel[3];
      else if (tick_fall) din_q <= cmd_sh_q[11] && busy_q;
      if (conv_done) data_q <= {shift_q[10:0], dout_m};
      unread_q <= conv_done || (unread_q && !unread_clr);
      ovr_q <= overrun;
      rdy_q <= batt_fin || scan_fin;
      pen_irq_q <= (state_q == tpss_pkg::TPSS_WAIT_TOUCH && pen_rise)
        || (state_q == tpss_pkg::TPSS_INTERVAL_WAIT && pen_fall);
      if (state_q != tpss_pkg::TPSS_COORD_SCAN || scan_end) idx_q <= 3'h0;
      else if (conv_done) idx_q <= idx_q + 3'h1;
      if (state_q == tpss_pkg::TPSS_WAIT_TOUCH && pen_rise) chk_q <= `TPSS_PEN_CHECK_TICKS;
      else if (chk_q != 3'h0 && tick_rise) chk_q <= chk_q - 3'h1;
      if (state_q != tpss_pkg::TPSS_INTERVAL_WAIT) ivl_cnt_q <= '0;
      else if (tick_rise && !ivl_done) ivl_cnt_q <= ivl_cnt_q + 1'b1;
    end
  end

  assign converter_clock = clk_q && oe_q;
  assign conv_cs_n = cs_n_q;
  assign conv_din = din_q;
  assign panel_drive_field = drive_q;
  assign pins_oe = oe_q;
  assign sample_ready_irq = rdy_q;
  assign pen_change_irq = pen_irq_q;
  assign sample_overrun_irq = ovr_q;
  assign suspend_ok = susp_q;

  chk_disabled_hiz: assert property (@(posedge clock) disable iff (rst)
    $past(state_q) == tpss_pkg::TPSS_DISABLED && state_q == tpss_pkg::TPSS_DISABLED
    |-> !pins_oe) else $error("pins driven while disabled");
  chk_standby_quiet: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_STANDBY [*2] |-> conv_cs_n && panel_drive_field == 5'h00)
    else $error("standby drives panel or converter");
  chk_batt_return: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_MAIN_BATT && conv_done && pwr_q && !unit_rst
    |=> state_q == tpss_pkg::TPSS_STANDBY && sample_ready_irq)
    else $error("main battery did not finish");
  chk_sub_return: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_SUB_BATT && conv_done && en_q && pwr_q && !unit_rst
    |=> state_q == tpss_pkg::TPSS_STANDBY ##1 state_q == tpss_pkg::TPSS_STANDBY)
    else $error("sub battery did not return");
  chk_cmd_drive: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_COMMAND && conv_go
    |=> panel_drive_field == $past(manual_command_reg[4:0]))
    else $error("command drive mismatch");
  chk_pen_irq: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_WAIT_TOUCH && pen_rise |=> pen_change_irq)
    else $error("touch without pen change");
  chk_coord_ready: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_COORD_SCAN && scan_last && !dmamsk_q |=> sample_ready_irq)
    else $error("coordinate done without sample ready");
  chk_overrun_flag: assert property (@(posedge clock) disable iff (rst)
    conv_done && unread_q |=> sample_overrun_irq && dma_data == $past({shift_q[10:0], dout_m}))
    else $error("overwrite not flagged");
  chk_unit_reset: assert property (@(posedge clock) disable iff (rst)
    unit_rst |=> state_q == tpss_pkg::TPSS_DISABLED ##1 !pins_oe)
    else $error("unit reset did not disable");
  chk_interval_end: assert property (@(posedge clock) disable iff (rst)
    state_q == tpss_pkg::TPSS_INTERVAL_WAIT && ivl_done && en_q && pwr_q && !unit_rst
    |=> state_q == tpss_pkg::TPSS_COORD_SCAN) else $error("interval did not rescan");
endmodule

/* verif/tpss_adc_model.sv */
// behavioural model of the serial converter and the touch panel
`timescale 1ns/10ps
module tpss_adc_model (
  input wire logic converter_clock, // clock from the sequencer
  input wire logic conv_cs_n, // converter select, active low
  input wire logic conv_din, // command bits from the sequencer
  input wire logic [11:0] sample_val, // result returned in the next frame
  input wire logic pen_in, // panel pressed by the bench
  output logic pen_touch, // touch sense to the sequencer
  output logic conv_dout, // serial result, msb first
  output logic [11:0] cmd_seen // last twelve command bits
);
  logic [11:0] sh_q = 12'h000;
  initial conv_dout = 1'b0;
  initial cmd_seen = 12'h000;
  assign pen_touch = pen_in;
  // first bit ready as soon as selected
  always @(negedge conv_cs_n) begin
    sh_q = sample_val;
    conv_dout = sample_val[11];
  end
  // result changes on the falling clock, sampled on the rise
  always @(negedge converter_clock) begin
    if (!conv_cs_n) begin
      sh_q = {sh_q[10:0], 1'b0};
      conv_dout = sh_q[11];
    end
  end
  // deselected: line no longer shows the last bit
  always @(posedge conv_cs_n) conv_dout = ~conv_dout;
  always @(posedge converter_clock) begin
    if (!conv_cs_n) cmd_seen = {cmd_seen[10:0], conv_din};
  end
endmodule

/* verif/tb.sv */
// self-checking bench of the touch scan sequencer
`timescale 1ns/10ps
`include "tpss_consts.svh"
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, dma_ack = 1'b0, pen_in = 1'b0;
  logic [11:0] val = 12'h000;
  logic awready, wready, bvalid, arready, rvalid, dma_req, sri, pci, soi, suspend_ok;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] dma_data, cmd_seen;
  logic pen_touch, conv_dout, converter_clock, conv_cs_n, conv_din, pins_oe;
  logic [4:0] panel_drive_field;
  logic [4:0] drv_q[$];
  logic [4:0] exp_drv[5] = '{`TPSS_DRV_XFWD, `TPSS_DRV_XREV, `TPSS_DRV_YFWD, `TPSS_DRV_YREV,
    `TPSS_DRV_PRESS};
  int cnt[4] = '{0, 0, 0, 0};
  int n_fail = 0, checks_done = 0;
  time t0 = 0, per = 0;
  always #50 clock = ~clock;
  tpss_top #(.DIV_W(8), .IVL_W(16)) u_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .dma_req(dma_req), .dma_ack(dma_ack), .dma_data(dma_data),
    .sample_ready_irq(sri), .pen_change_irq(pci), .sample_overrun_irq(soi),
    .suspend_ok(suspend_ok), .pen_touch(pen_touch), .conv_dout(conv_dout),
    .converter_clock(converter_clock), .conv_cs_n(conv_cs_n), .conv_din(conv_din),
    .panel_drive_field(panel_drive_field), .pins_oe(pins_oe));
  tpss_adc_model u_adc (.converter_clock(converter_clock), .conv_cs_n(conv_cs_n),
    .conv_din(conv_din), .sample_val(val), .pen_in(pen_in), .pen_touch(pen_touch),
    .conv_dout(conv_dout), .cmd_seen(cmd_seen));
  always @(posedge clock) begin
    dma_ack <= (dma_req === 1'b1) && !dma_ack;
    if (sri === 1'b1) cnt[0]++;
    if (pci === 1'b1) cnt[1]++;
    if (soi === 1'b1) cnt[2]++;
    if (dma_ack) cnt[3]++;
  end
  always @(negedge conv_cs_n) begin
    #1;
    drv_q.push_back(panel_drive_field);
  end
  always @(posedge converter_clock) begin
    per = $time - t0;
    t0 = $time;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic fail_out();
    n_fail++;
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit done;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; done = 0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk("bresp", {30'h0, `TPSS_RESP_OKAY}, {30'h0, bresp});
        done = 1;
      end
    end
    if (!done) fail_out();
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    araddr <= a; arvalid <= 1'b1; done = 0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata; r = rresp; done = 1;
      end
    end
    if (!done) fail_out();
  endtask
  task automatic wait_state(input logic [2:0] s);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 300; n++) begin
      axi_read(`TPSS_ADDR_STAT, d, r);
      if (d[2:0] === s) break;
    end
    chk("state", {29'h0, s}, {29'h0, d[2:0]});
  endtask
  task automatic wait_cnt(input int i, input int t);
    for (int n = 0; n < 4000 && cnt[i] < t; n++) @(posedge clock);
    if (cnt[i] < t) fail_out();
  endtask
  initial begin
    #9000000;
    fail_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r, md;
    logic [15:0] s;
    int c, q;
    s = 16'h6247;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("oe", 0, pins_oe);
    wait_state(tpss_pkg::TPSS_DISABLED);
    axi_read(`TPSS_ADDR_IVL, d, r);
    chk("ivl", {16'h0, `TPSS_IVL_RST}, d);
    axi_read(`TPSS_ADDR_CDIV, d, r);
    chk("cdiv", {24'h0, `TPSS_CDIV_RST}, d);
    axi_read(8'h18, d, r);
    chk("rresp", {30'h0, `TPSS_RESP_SLVERR}, {30'h0, r});
    axi_write(`TPSS_ADDR_CDIV, 32'h3);
    axi_write(`TPSS_ADDR_CTRL, 32'h2);
    wait_state(tpss_pkg::TPSS_STANDBY);
    chk("oe", 1, pins_oe);
    chk("cs", 1, conv_cs_n);
    chk("drive", 0, panel_drive_field);
    for (int i = 0; i < 3; i++) begin
      md = (i == 0) ? 2'h2 : (i == 1) ? 2'h3 : 2'h1;
      s = lfsr(s);
      val <= s[11:0];
      axi_write(`TPSS_ADDR_CMD, {19'h0, s[15:12], 4'h0, s[4:0]});
      axi_write(`TPSS_ADDR_CTRL, {27'h0, md, 3'b010});
      drv_q.delete();
      c = cnt[0];
      axi_write(`TPSS_ADDR_CTRL, {27'h0, md, 3'b011});
      wait_cnt(0, c + 1);
      chk("data", {20'h0, s[11:0]}, {20'h0, dma_data});
      wait_state(tpss_pkg::TPSS_STANDBY);
      chk("period", 800, per[31:0]);
      if (md == 2'h1) begin
        chk("cmd drive", {27'h0, s[4:0]}, {27'h0, drv_q[0]});
        chk("cmd word", {28'h0, s[15:12]}, {28'h0, cmd_seen[11:8]});
      end
    end
    axi_write(`TPSS_ADDR_IVL, 32'h20);
    axi_write(`TPSS_ADDR_CTRL, 32'h0422);
    axi_write(`TPSS_ADDR_CTRL, 32'h0423);
    wait_state(tpss_pkg::TPSS_WAIT_TOUCH);
    chk("suspend", 1, suspend_ok);
    pen_in <= 1'b1;
    repeat (8) @(posedge clock);
    pen_in <= 1'b0;
    repeat (100) @(posedge clock);
    axi_read(`TPSS_ADDR_STAT, d, r);
    chk("short touch", {29'h0, tpss_pkg::TPSS_WAIT_TOUCH}, {29'h0, d[2:0]});
    drv_q.delete();
    c = cnt[0];
    q = cnt[3];
    pen_in <= 1'b1;
    wait_cnt(1, cnt[1] + 1);
    wait_cnt(0, c + 1);
    repeat (4) @(posedge clock);
    chk("frames", 5, drv_q.size());
    chk("dma", q + 5, cnt[3]);
    for (int i = 0; i < 5; i++) begin
      chk("scan drive", {27'h0, exp_drv[i]}, {27'h0, drv_q[i]});
    end
    wait_state(tpss_pkg::TPSS_INTERVAL_WAIT);
    wait_cnt(0, c + 2);
    c = cnt[1];
    pen_in <= 1'b0;
    wait_cnt(1, c + 1);
    c = cnt[0];
    pen_in <= 1'b1;
    axi_write(`TPSS_ADDR_CTRL, 32'h0C23);
    wait_cnt(2, cnt[2] + 1);
    chk("ready masked", c, cnt[0]);
    chk("dma masked", 0, dma_req);
    axi_write(`TPSS_ADDR_CTRL, 32'h0C22);
    wait_state(tpss_pkg::TPSS_STANDBY);
    axi_write(`TPSS_ADDR_CTRL, 32'h0122);
    wait_state(tpss_pkg::TPSS_WAIT_TOUCH);
    axi_write(`TPSS_ADDR_CTRL, 32'h0022);
    wait_state(tpss_pkg::TPSS_STANDBY);
    c = cnt[0];
    axi_write(`TPSS_ADDR_CTRL, 32'h00E3);
    wait_cnt(0, c + 1);
    wait_state(tpss_pkg::TPSS_STANDBY);
    axi_write(`TPSS_ADDR_CTRL, 32'h0006);
    wait_state(tpss_pkg::TPSS_DISABLED);
    axi_write(`TPSS_ADDR_CTRL, 32'h0002);
    wait_state(tpss_pkg::TPSS_STANDBY);
    axi_write(`TPSS_ADDR_CTRL, 32'h0);
    wait_state(tpss_pkg::TPSS_DISABLED);
    chk("oe off", 0, pins_oe);
    print_verdict();
  end
endmodule
